// *** cvb_defines.svh ***
`ifndef CVB_DEFINES_SVH
`define CVB_DEFINES_SVH
`define CVB_IDX_VERSION 10'h007
`define CVB_IDX_MAKER 10'h008
`define CVB_IDX_ADDR 10'h001
`define CVB_IDX_TIMEOUT 10'h00b
`define CVB_IDX_MODES 10'h00c
`define CVB_IDX_KEY 10'h00f
`define CVB_IDX_LOCKVAL 10'h010
`define CVB_IDX_REGEN 10'h01c
`define CVB_IDX_CONFIG 10'h01d
`define CVB_IDX_PAGE_HI 10'h01f
`define CVB_IDX_PAGE_LO 10'h020
`define CVB_IDX_METHOD 10'h060
`define CVB_IDX_MINON_LO 10'h061
`define CVB_IDX_INMAP_LO 10'h069
`define CVB_IDX_LOADCTL 10'h074
`define CVB_IDX_ABC_EN 10'h079
`define CVB_IDX_ABC_SENS 10'h07a
`define CVB_IDX_MAP_LO 10'h101
`define CVB_IDX_MAP_HI 10'h200
`define CVB_RST_KEY 8'h03
`define CVB_RST_LOCKVAL 8'h03
`define CVB_RST_MODES 8'h35
`define CVB_RST_PAGE_HI 8'h00
`define CVB_RST_PAGE_LO 8'h2a
`define CVB_RST_METHOD 8'h02
`define CVB_RST_ADDR 8'h03
`define CVB_RST_CONFIG 8'h06
`define CVB_RST_TIMEOUT 8'h05
`define CVB_RST_REGEN 8'h01
`define CVB_RST_ABC_SENS 8'h0a
`define CVB_RST_MINON 8'h05
`define CVB_SHORT_ADDR_MAX 8'h7f
`define CVB_CFG_EXT_BIT 5
`define CVB_CFG_FB_BIT 3
`define CVB_CFG_ANA_BIT 2
`define CVB_MODE_DC 8'h01
`define CVB_MODE_DCC 8'h04
`define CVB_MODE_AC 8'h10
`define CVB_MODE_ALT 8'h20
`define CVB_TIMEOUT_UNIT_MS 100
`define CVB_CLK_MHZ 100
`define CVB_MINON_UNIT_MS 1
`define CVB_FLASH_MS 250
`endif

// *** cvb_pkg.sv ***
package cvb_pkg;
  typedef enum logic [1:0] {
    CVB_SRC_DCC = 2'b01,
    CVB_SRC_ALT = 2'b10
  } cvb_src_e;
  typedef logic [7:0] cvb_byte_t;
endpackage

// *** cvb_bank.sv ***
`include "cvb_defines.svh"
module cvb_bank
  import cvb_pkg::*;
#(
  parameter int NUM_INPUTS = 2,
  parameter int TIMEOUT_UNIT_CYC = `CVB_TIMEOUT_UNIT_MS * `CVB_CLK_MHZ * 1000,
  parameter int MINON_UNIT_CYC = `CVB_MINON_UNIT_MS * `CVB_CLK_MHZ * 1000,
  parameter int FLASH_CYC = `CVB_FLASH_MS * `CVB_CLK_MHZ * 1000,
  // Arbitrary neutral values
  parameter logic [7:0] MAKER_ID = 8'h55,
  parameter logic [7:0] FW_VERSION = 8'h01
) (
  // Clock, reset (i_srst models power-up)
  input wire logic i_mclk,
  input wire logic i_srst,
  // Configuration variable access from the packet decoder
  input wire logic i_cv_wr,
  input wire logic i_cv_rd,
  input wire logic [1:0] i_cv_src,
  input wire logic i_cv_feedback,
  input wire logic [9:0] i_cv_idx,
  input wire logic [7:0] i_cv_wdata,
  output logic o_cv_rvalid,
  output logic [7:0] o_cv_rdata,
  output logic o_cv_wr_refused,
  // Track and command qualification
  input wire logic i_packet_seen,
  input wire logic i_run_cmd,
  input wire logic i_overload,
  input wire logic i_asym_level,
  input wire logic [NUM_INPUTS-1:0] i_switch_in,
  output logic o_dcc_accept,
  output logic o_alt_accept,
  output logic o_run_enable,
  output logic o_headlight_flash,
  output logic o_analogue_mode,
  output logic o_abc_brake,
  output logic o_registration_en,
  output logic o_load_ctl_en,
  output logic [7:0] o_switch_func,
  output logic [NUM_INPUTS-1:0] o_switch_trig
);
  // Refuse sizes that the storage map cannot serve
  if (NUM_INPUTS < 1 || NUM_INPUTS > 4) begin : g_chk_inputs
    $error("NUM_INPUTS must be 1 to 4");
  end
  if (TIMEOUT_UNIT_CYC < 1 || MINON_UNIT_CYC < 1 || FLASH_CYC < 1) begin : g_chk_counts
    $error("Unit counts must be at least 1");
  end

  // One slot for every variable number up to the top of the mapping area
  localparam int NUM_CVS = 32'(`CVB_IDX_MAP_HI) + 1;
  logic [7:0] cv_r [0:NUM_CVS-1];
  logic unlocked;
  logic in_range;
  logic key_wr;
  logic lock_ok;
  logic area_ok;
  logic src_ok;
  logic fb_on;
  logic map_open;
  logic is_map;
  logic page_idx;
  logic ro_idx;
  logic wr_ok;
  logic factory_rst;
  logic [7:0] rd_nxt;
  logic rd_ok;

  assign unlocked = cv_r[`CVB_IDX_KEY] == cv_r[`CVB_IDX_LOCKVAL];
  assign map_open = cv_r[`CVB_IDX_PAGE_HI] == `CVB_RST_PAGE_HI &&
                    cv_r[`CVB_IDX_PAGE_LO] == `CVB_RST_PAGE_LO;
  assign is_map = i_cv_idx >= `CVB_IDX_MAP_LO && i_cv_idx <= `CVB_IDX_MAP_HI;
  assign page_idx = i_cv_idx == `CVB_IDX_PAGE_HI || i_cv_idx == `CVB_IDX_PAGE_LO;
  assign ro_idx = i_cv_idx == `CVB_IDX_VERSION || i_cv_idx == `CVB_IDX_MODES ||
                  i_cv_idx == `CVB_IDX_METHOD;
  assign in_range = i_cv_idx <= `CVB_IDX_MAP_HI;
  assign fb_on = cv_r[`CVB_IDX_CONFIG][`CVB_CFG_FB_BIT];
  // The key stays writable while locked, or a locked bank could never be opened again
  assign key_wr = i_cv_idx == `CVB_IDX_KEY;
  assign lock_ok = unlocked || key_wr;
  assign area_ok = !(is_map && !map_open);
  assign src_ok = !(page_idx && i_cv_src != CVB_SRC_DCC);
  // Refused writes touch neither storage nor the reset trigger
  assign wr_ok = i_cv_wr && lock_ok && area_ok && src_ok && !ro_idx && in_range;
  assign factory_rst = wr_ok && i_cv_idx == `CVB_IDX_MAKER;

  // Factory values; any number not listed clears to zero
  function automatic logic [7:0] cv_default(input int idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      32'(`CVB_IDX_ADDR): v = `CVB_RST_ADDR;
      32'(`CVB_IDX_TIMEOUT): v = `CVB_RST_TIMEOUT;
      32'(`CVB_IDX_MODES): v = `CVB_RST_MODES;
      32'(`CVB_IDX_KEY): v = `CVB_RST_KEY;
      32'(`CVB_IDX_LOCKVAL): v = `CVB_RST_LOCKVAL;
      32'(`CVB_IDX_REGEN): v = `CVB_RST_REGEN;
      32'(`CVB_IDX_CONFIG): v = `CVB_RST_CONFIG;
      32'(`CVB_IDX_PAGE_LO): v = `CVB_RST_PAGE_LO;
      32'(`CVB_IDX_METHOD): v = `CVB_RST_METHOD;
      32'(`CVB_IDX_ABC_SENS): v = `CVB_RST_ABC_SENS;
      32'(`CVB_IDX_LOADCTL): v = 8'h01;
      32'(`CVB_IDX_ABC_EN): v = 8'h01;
      default: v = 8'h00;
    endcase
    if (idx >= 32'(`CVB_IDX_MINON_LO) && idx < 32'(`CVB_IDX_MINON_LO) + 2) begin
      v = `CVB_RST_MINON;
    end
    if (idx >= 32'(`CVB_IDX_INMAP_LO) && idx < 32'(`CVB_IDX_INMAP_LO) + 4) begin
      v = 8'(idx - 32'(`CVB_IDX_INMAP_LO) + 1);
    end
    return v;
  endfunction

  // A factory reset wins over storing the write that carries it
  always_ff @(posedge i_mclk) begin
    for (int k = 0; k < NUM_CVS; k++) begin
      if (i_srst) begin
        cv_r[k] <= cv_default(k);
      end else if (factory_rst) begin
        if (k != 32'(`CVB_IDX_LOCKVAL)) begin
          cv_r[k] <= cv_default(k);
        end
      end else if (wr_ok && i_cv_idx == 10'(k)) begin
        cv_r[k] <= i_cv_wdata;
      end
    end
  end

  // Read path: fixed values and source/feedback gating
  always_comb begin
    rd_nxt = 8'h00;
    rd_ok = in_range;
    // Numbers past the bank never index the array, so no unknown can leave
    if (in_range) begin
      rd_nxt = cv_r[i_cv_idx];
    end
    if (i_cv_idx == `CVB_IDX_VERSION) begin
      rd_nxt = FW_VERSION;
      rd_ok = i_cv_src == CVB_SRC_DCC;
    end else if (i_cv_idx == `CVB_IDX_MAKER) begin
      rd_nxt = MAKER_ID;
      rd_ok = i_cv_src == CVB_SRC_DCC;
    end
    if (i_cv_feedback && !fb_on) begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_cv_rvalid <= 1'b0;
      o_cv_rdata <= 8'h00;
      o_cv_wr_refused <= 1'b0;
    end else begin
      o_cv_rvalid <= i_cv_rd && rd_ok;
      o_cv_rdata <= (i_cv_rd && rd_ok) ? rd_nxt : 8'h00;
      // The refusal pulse lets the station tell a lock from a lost packet
      o_cv_wr_refused <= i_cv_wr && !wr_ok;
    end
  end

  // Input synchronisers for pins
  logic [1:0] ovl_s, asym_s, pkt_s;
  logic [NUM_INPUTS-1:0] sw_s1, sw_s2;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ovl_s <= 2'b00;
      asym_s <= 2'b00;
      pkt_s <= 2'b00;
      sw_s1 <= '0;
      sw_s2 <= '0;
    end else begin
      ovl_s <= {ovl_s[0], i_overload};
      asym_s <= {asym_s[0], i_asym_level};
      pkt_s <= {pkt_s[0], i_packet_seen};
      sw_s1 <= i_switch_in;
      sw_s2 <= sw_s1;
    end
  end

  // Address mode qualification
  logic ext_on;
  logic short_ok;
  assign ext_on = cv_r[`CVB_IDX_CONFIG][`CVB_CFG_EXT_BIT];
  assign short_ok = cv_r[`CVB_IDX_ADDR] <= `CVB_SHORT_ADDR_MAX;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_dcc_accept <= 1'b0;
      o_alt_accept <= 1'b0;
      o_registration_en <= 1'b0;
      o_load_ctl_en <= 1'b0;
    end else begin
      o_dcc_accept <= ext_on || short_ok;
      o_alt_accept <= !ext_on;
      o_registration_en <= cv_r[`CVB_IDX_CONFIG][`CVB_CFG_FB_BIT] &&
                           cv_r[`CVB_IDX_REGEN] != 8'h00;
      o_load_ctl_en <= cv_r[`CVB_IDX_LOADCTL] != 8'h00;
    end
  end

  // Overload latch clears only on power-up reset
  logic ovl_r;
  logic [31:0] flash_cnt_r;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ovl_r <= 1'b0;
      flash_cnt_r <= '0;
      o_headlight_flash <= 1'b0;
      o_run_enable <= 1'b0;
    end else begin
      if (ovl_s[1]) begin
        ovl_r <= 1'b1;
      end
      if (ovl_r && flash_cnt_r == 32'(FLASH_CYC - 1)) begin
        flash_cnt_r <= '0;
        o_headlight_flash <= !o_headlight_flash;
      end else if (ovl_r) begin
        flash_cnt_r <= flash_cnt_r + 32'd1;
      end
      // The synchronised level also stops the motor, in the same cycle that the latch sets
      o_run_enable <= i_run_cmd && !ovl_r && !ovl_s[1];
    end
  end

  // Asymmetric braking: level must persist for sensitivity+1 cycles
  logic [7:0] asym_cnt_r;
  logic abc_on;
  assign abc_on = cv_r[`CVB_IDX_ABC_EN] != 8'h00;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      asym_cnt_r <= 8'h00;
      o_abc_brake <= 1'b0;
    end else begin
      if (!asym_s[1]) begin
        asym_cnt_r <= 8'h00;
      end else if (asym_cnt_r != 8'hff) begin
        asym_cnt_r <= asym_cnt_r + 8'h01;
      end
      o_abc_brake <= abc_on && asym_s[1] &&
                     asym_cnt_r >= cv_r[`CVB_IDX_ABC_SENS];
    end
  end

  // Packet timeout for analogue fallback
  logic [31:0] tick_r;
  logic [7:0] units_r;
  logic ana_on;
  assign ana_on = cv_r[`CVB_IDX_CONFIG][`CVB_CFG_ANA_BIT] && cv_r[`CVB_IDX_TIMEOUT] != 8'h00;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tick_r <= '0;
      units_r <= 8'h00;
      o_analogue_mode <= 1'b0;
    end else if (pkt_s[1]) begin
      tick_r <= '0;
      units_r <= 8'h00;
      o_analogue_mode <= 1'b0;
    end else begin
      if (tick_r == 32'(TIMEOUT_UNIT_CYC - 1)) begin
        tick_r <= '0;
        // Saturates, so a long silence cannot wrap back out of analogue mode
        if (units_r != 8'hff) begin
          units_r <= units_r + 8'h01;
        end
      end else begin
        tick_r <= tick_r + 32'd1;
      end
      o_analogue_mode <= ana_on &&
                         units_r >= cv_r[`CVB_IDX_TIMEOUT];
    end
  end

  // Switching inputs with minimum on-time
  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g++) begin : g_sw
      logic [31:0] ms_r;
      logic [7:0] on_r;
      logic [7:0] minon;
      assign minon = cv_r[`CVB_IDX_MINON_LO + (g % 2)];
      // Dropping the input restarts the count, so a short blip never adds to a press
      always_ff @(posedge i_mclk) begin
        if (i_srst || !sw_s2[g]) begin
          ms_r <= '0;
          on_r <= 8'h00;
          o_switch_trig[g] <= 1'b0;
        end else begin
          if (ms_r == 32'(MINON_UNIT_CYC - 1)) begin
            ms_r <= '0;
            if (on_r != 8'hff) begin
              on_r <= on_r + 8'h01;
            end
          end else begin
            ms_r <= ms_r + 32'd1;
          end
          o_switch_trig[g] <= on_r == minon && ms_r == 32'd0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_switch_func <= 8'h00;
    end else begin
      // With several inputs active the highest one wins
      for (int j = 0; j < NUM_INPUTS; j++) begin
        if (g_on(j)) begin
          o_switch_func <= cv_r[`CVB_IDX_INMAP_LO + j];
        end
      end
    end
  end

  function automatic logic g_on(input int j);
    return sw_s2[j];
  endfunction
endmodule

// *** cvb_bank_sva.sv ***
module cvb_bank_sva
  import cvb_pkg::*;
(
  // Clock, reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Watched ports
  input wire logic i_cv_wr,
  input wire logic i_cv_rd,
  input wire logic [1:0] i_cv_src,
  input wire logic i_cv_feedback,
  input wire logic [9:0] i_cv_idx,
  input wire logic i_run_cmd,
  input wire logic o_cv_rvalid,
  input wire logic [7:0] o_cv_rdata,
  input wire logic o_cv_wr_refused,
  input wire logic o_dcc_accept,
  input wire logic o_alt_accept,
  input wire logic o_run_enable,
  input wire logic o_headlight_flash,
  input wire logic o_registration_en
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence s_rd(logic [9:0] n);
    i_cv_rd && i_cv_src == CVB_SRC_DCC && !i_cv_feedback && i_cv_idx == n;
  endsequence
  sequence s_alt(logic w, logic [9:0] n);
    (w ? i_cv_wr : i_cv_rd) && i_cv_src == CVB_SRC_ALT && i_cv_idx == n;
  endsequence
  chk_modes_read: assert property (s_rd(10'h00c) |=> o_cv_rvalid && o_cv_rdata == 8'h35)
    else $error("modes read wrong");
  chk_method_read: assert property (s_rd(10'h060) |=> o_cv_rvalid && o_cv_rdata == 8'h02)
    else $error("method read wrong");
  chk_alt_info: assert property (s_alt(0, 10'h007) or s_alt(0, 10'h008) |=> !o_cv_rvalid)
    else $error("info read answered off format");
  chk_alt_page: assert property (s_alt(1, 10'h01f) or s_alt(1, 10'h020) |=> o_cv_wr_refused)
    else $error("page index written off format");
  chk_ro_write: assert property (i_cv_wr && i_cv_idx inside {10'h007, 10'h00c, 10'h060} |=> o_cv_wr_refused)
    else $error("read-only write taken");
  chk_refuse_cause: assert property (o_cv_wr_refused |-> $past(i_cv_wr))
    else $error("refusal without write");
  chk_rvalid_cause: assert property (o_cv_rvalid |-> $past(i_cv_rd) && !o_cv_wr_refused)
    else $error("answer without read");
  chk_run_cause: assert property (o_run_enable |-> $past(i_run_cmd))
    else $error("run without command");
  chk_flash_stop: assert property ($changed(o_headlight_flash) |-> !o_run_enable)
    else $error("flashing while running");
  chk_fb_read: assert property (i_cv_rd && i_cv_feedback && i_cv_src == CVB_SRC_DCC &&
    i_cv_idx <= 10'h200 && o_registration_en && !$past(i_cv_wr) |=> o_cv_rvalid)
    else $error("feedback read refused");
  chk_addr_modes: assert property (!$past(i_srst) && !o_alt_accept |-> o_dcc_accept)
    else $error("extended mode deaf to packets");
endmodule

bind cvb_bank cvb_bank_sva u_cvb_bank_sva (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_cv_wr(i_cv_wr), .i_cv_rd(i_cv_rd), .i_cv_src(i_cv_src), .i_cv_feedback(i_cv_feedback),
  .i_cv_idx(i_cv_idx), .i_run_cmd(i_run_cmd), .o_cv_rvalid(o_cv_rvalid),
  .o_cv_rdata(o_cv_rdata), .o_cv_wr_refused(o_cv_wr_refused), .o_dcc_accept(o_dcc_accept),
  .o_alt_accept(o_alt_accept), .o_run_enable(o_run_enable),
  .o_headlight_flash(o_headlight_flash), .o_registration_en(o_registration_en));

// *** cvb_station.sv ***
module cvb_station
  import cvb_pkg::*;
(
  input wire logic i_mclk,
  // Request lines
  output logic o_wr,
  output logic o_rd,
  output logic [1:0] o_src,
  output logic o_fb,
  output logic [9:0] o_idx,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Station runs the decoder's speed-step mode, so light bits never alias
  localparam int STEPS = 28;
  initial begin
    o_wr = 0;
    o_rd = 0;
    o_src = CVB_SRC_DCC;
    o_fb = 0;
    o_idx = '0;
    o_wdata = '0;
  end
  task automatic xfer(input logic w, input logic [1:0] s, input logic f,
                      input logic [9:0] i, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_wr = w;
    o_rd = !w;
    o_src = s;
    o_fb = f;
    o_idx = i;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    o_wr = 0;
    o_rd = 0;
    // Released lines show inverted data so a stale value cannot pass
    o_idx = ~i;
    o_wdata = ~d;
  endtask
endmodule

// *** testbench.sv ***
module testbench;
  import cvb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, pkt = 0, run = 0, ovl = 0, asym = 0;
  logic [1:0] sw = 0, src, trig;
  logic wr, rd, fb, rv, rf, dcc, alt, run_en, flash, ana, brk, reg_en, load, v, r;
  logic [9:0] idx;
  logic [7:0] wd, rq, fn, q;
  int error_cnt = 0, check_count = 0, n;
  always #5 clk = ~clk;
  cvb_station u_cvb_station (.i_mclk(clk), .o_wr(wr), .o_rd(rd), .o_src(src), .o_fb(fb),
    .o_idx(idx), .o_wdata(wd));
  cvb_bank #(.TIMEOUT_UNIT_CYC(4), .MINON_UNIT_CYC(4), .FLASH_CYC(4)) u_cvb_bank (
    .i_mclk(clk), .i_srst(srst), .i_cv_wr(wr), .i_cv_rd(rd), .i_cv_src(src),
    .i_cv_feedback(fb), .i_cv_idx(idx), .i_cv_wdata(wd), .o_cv_rvalid(rv),
    .o_cv_rdata(rq), .o_cv_wr_refused(rf), .i_packet_seen(pkt), .i_run_cmd(run),
    .i_overload(ovl), .i_asym_level(asym), .i_switch_in(sw), .o_dcc_accept(dcc),
    .o_alt_accept(alt), .o_run_enable(run_en), .o_headlight_flash(flash),
    .o_analogue_mode(ana), .o_abc_brake(brk), .o_registration_en(reg_en),
    .o_load_ctl_en(load), .o_switch_func(fn), .o_switch_trig(trig));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [1:0] s, input logic f,
                     input logic [9:0] i, input logic [7:0] d);
    u_cvb_station.xfer(w, s, f, i, d);
    // The answer stands only in the cycle right after the taking edge
    v = rv;
    q = rq;
    r = rf;
  endtask
  task automatic wrc(input logic [9:0] i, input logic [7:0] d, input logic e);
    acc(1, CVB_SRC_DCC, 0, i, d);
    chk(r, e);
  endtask
  task automatic rdc(input logic [9:0] i, input logic [7:0] e);
    acc(0, CVB_SRC_DCC, 0, i, 0);
    chk({v, q}, {1'b1, e});
  endtask
  task automatic pwr();
    srst = 1;
    wt(3);
    srst = 0;
  endtask
  task automatic t_info();
    rdc(10'h00c, 8'h35);
    rdc(10'h060, 8'h02);
    rdc(10'h010, 8'h03);
    rdc(10'h007, 8'h01);
    rdc(10'h008, 8'h55);
    acc(0, CVB_SRC_ALT, 0, 10'h008, 0);
    chk(v, 0);
    acc(1, CVB_SRC_ALT, 0, 10'h01f, 8'h05);
    chk(r, 1);
    rdc(10'h01f, 8'h00);
    wrc(10'h00c, 8'h00, 1);
  endtask
  task automatic t_page();
    wrc(10'h101, 8'h11, 0);
    wrc(10'h020, 8'h01, 0);
    wrc(10'h200, 8'h22, 1);
    wrc(10'h020, 8'h2a, 0);
    wrc(10'h200, 8'h22, 0);
    rdc(10'h101, 8'h11);
    rdc(10'h200, 8'h22);
    wrc(10'h001, 8'h10, 0);
    wrc(10'h008, 8'h5a, 0);
    rdc(10'h001, 8'h03);
    rdc(10'h010, 8'h03);
  endtask
  task automatic t_addr();
    wrc(10'h001, 8'h7f, 0);
    wt(3);
    chk(dcc, 1);
    wrc(10'h001, 8'h80, 0);
    wt(3);
    chk({dcc, alt}, 2'b01);
    wrc(10'h01d, 8'h26, 0);
    wt(3);
    chk({dcc, alt}, 2'b10);
    wrc(10'h01d, 8'h06, 0);
    wrc(10'h001, 8'h03, 0);
    acc(0, CVB_SRC_DCC, 1, 10'h00f, 0);
    chk({v, reg_en}, 2'b00);
    wrc(10'h01d, 8'h0e, 0);
    acc(0, CVB_SRC_DCC, 1, 10'h00f, 0);
    chk({v, reg_en}, 2'b11);
    wrc(10'h01c, 8'h00, 0);
    wt(2);
    chk(reg_en, 0);
  endtask
  task automatic t_lvl();
    pkt = 1;
    wt(3);
    pkt = 0;
    wt(15);
    chk(ana, 0);
    wt(12);
    chk(ana, 1);
    wrc(10'h01d, 8'h02, 0);
    wt(3);
    chk(ana, 0);
    wrc(10'h07a, 8'h1e, 0);
    asym = 1;
    wt(16);
    chk(brk, 0);
    wt(20);
    chk(brk, 1);
    asym = 0;
    wrc(10'h079, 8'h00, 0);
    asym = 1;
    wt(40);
    chk(brk, 0);
    chk(load, 1);
    wrc(10'h074, 8'h00, 0);
    wt(2);
    chk(load, 0);
    for (int j = 0; j < 2; j++) begin
      // A short blip first: its on-time must not count toward the second press
      sw = 2'(1 << j);
      wt(8);
      sw = 0;
      wt(2);
      sw = 2'(1 << j);
      n = 0;
      while (trig !== sw && n < 40) begin
        wt(1);
        n++;
      end
      chk(fn, 8'(j + 1));
      chk(n >= 18 && n <= 28, 1);
      sw = 0;
    end
  endtask
  task automatic t_ovl();
    run = 1;
    wt(2);
    chk(run_en, 1);
    ovl = 1;
    wt(5);
    ovl = 0;
    chk(run_en, 0);
    n = 0;
    while (flash !== 1 && n < 20) begin
      wt(1);
      n++;
    end
    chk(flash, 1);
    wt(20);
    chk(run_en, 0);
    pwr();
    wt(2);
    chk(run_en, 1);
    wrc(10'h010, 8'h09, 0);
    wrc(10'h001, 8'h44, 1);
    wrc(10'h008, 8'h00, 1);
    rdc(10'h010, 8'h09);
    rdc(10'h001, 8'h03);
    wrc(10'h00f, 8'h09, 0);
    wrc(10'h008, 8'h00, 0);
    rdc(10'h00f, 8'h03);
    rdc(10'h010, 8'h09);
  endtask
  task automatic close_out();
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #30000;
    error_cnt++;
    close_out();
  end
  initial begin
    pwr();
    t_info();
    t_page();
    t_addr();
    t_lvl();
    t_ovl();
    close_out();
  end
endmodule
